// >>> fwl_pkg.sv
package fwl_pkg;
  // ***********************************************************
  // register map (byte addresses, word aligned)
  // ***********************************************************
  localparam logic [7:0] ADDR_PAIR_OFS = 8'h00;
  localparam logic [7:0] DATA_PAIR_OFS = 8'h04;
  localparam logic [7:0] CONTROL_OFS = 8'h08;
  localparam logic [7:0] UNLOCK_OFS = 8'h0C;
  // ***********************************************************
  // control field positions
  // ***********************************************************
  localparam int CTL_WR_BIT = 1;
  localparam int CTL_WRITE_ENABLE_BIT_BIT = 2;
  localparam int CTL_ERR_BIT = 3;
  localparam int CTL_FREE_BIT = 4;
  localparam int CTL_LATCH_ONLY_BIT = 5;
  localparam int CTL_REGS_BIT = 6;
  localparam int CTL_DONE_BIT = 8;
  localparam int CTL_IE_BIT = 9;
  // ***********************************************************
  // values
  // ***********************************************************
  localparam logic [13:0] BLANK_WORD = 14'h3FFF;
  localparam logic [7:0] UNLOCK_CODE_A = 8'h55;
  localparam logic [7:0] UNLOCK_CODE_B = 8'hAA;
  localparam int ROW_WORDS = 32;
  localparam logic [15:0] UID_LO = 16'h8000;
  localparam logic [15:0] UID_HI = 16'h8003;
  localparam logic [15:0] DEVID_LO = 16'h8005;
  localparam logic [15:0] DEVID_HI = 16'h8006;
  localparam logic [15:0] CFG_LO = 16'h8007;
  localparam logic [15:0] CFG_HI = 16'h800B;
  localparam logic [15:0] INFO_LO = 16'h8100;
  localparam logic [15:0] INFO_HI = 16'h82FF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // self-timed program or erase time
  localparam int PROG_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PROG = 4'b0010,
    ST_ERASE = 4'b0100,
    ST_DONE = 4'b1000
  } fwl_state_type;
  typedef struct packed {
    logic rd_req;
    logic [15:0] addr;
    logic [13:0] wdata;
    logic [4:0] word;
  } fwl_flash_req_type;
endpackage : fwl_pkg

// >>> fwl_sequencer.sv
// Behaviour
// - row is address bits 14:5; bits 4:0 pick the latch to load
// - a program touches only the latches of the one addressed row
// - every latch returns to 0x3FFF when a program or erase ends
// - unloaded latches stay blank and program as blank words
// - 0x55 then 0xAA must precede write-start, else no operation starts and the error flag sets
// - erase 0, latch-only 1: data word goes to the addressed latch
// - latch loads ignore write protection
// - erase 0, latch-only 0: all latches program the row, data ignored
// - erase 1: whole 32-word row erased, latch-only and data ignored
// - protected erase or program: start clears, error sets, array kept
// - error flag on protected start, reset mid-write, broken unlock
// - software may set the error flag; only software clears it
// - no automatic erase precedes a program
// - one program always writes all 32 words of the row
// - region-select 1 steers access to the address-bit-15 areas
// - user id words 0x8000-0x8003 are read and write
// - configuration words 0x8007-0x800B are read and write
// - id words 0x8005-0x8006 read only
// - info area 0x8100-0x82FF read only
// - read outside valid region ranges clears the data pair
// - program and erase self-timed; write-start cleared at the end
// - write-enable 0 blocks every program and erase
// - erase done sets the done flag; interrupt if its enable set
// - cpu stalls while write-start is set
`timescale 1ns/1ps
module fwl_sequencer #(
  parameter int PROG_CNT = fwl_pkg::PROG_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash array side
  input wire logic [13:0] flash_rdata,
  input wire logic prot_hit,
  input wire logic reset_mid_write,
  output fwl_pkg::fwl_flash_req_type flash_req_r,
  output logic flash_prog_r,
  output logic flash_erase_r,
  output logic cpu_stall_r,
  output logic done_irq_r
);
  import fwl_pkg::*;

  // ***********************************************************
  // registers
  // ***********************************************************
  logic [14:0] addr_r;
  logic [13:0] data_r;
  logic regs_r, latch_only_r, free_r, err_r, write_enable_bit_r, wr_r, done_r, ie_r;
  logic unl_a_r, unl_b_r;
  logic [13:0] latch_r [ROW_WORDS];
  fwl_state_type state_r;
  logic [15:0] cnt_r;
  logic [4:0] word_r;
  logic rd_pend_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic aw_have_r, w_have_r;

  // ***********************************************************
  // bus decode
  // ***********************************************************
  wire wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  wire hit_addr = wr_fire && awaddr_r == ADDR_PAIR_OFS;
  wire hit_data = wr_fire && awaddr_r == DATA_PAIR_OFS;
  wire hit_ctl = wr_fire && awaddr_r == CONTROL_OFS;
  wire hit_unl = wr_fire && awaddr_r == UNLOCK_OFS;
  wire wr_known = hit_addr || hit_data || hit_ctl || hit_unl;
  wire idle = state_r == ST_IDLE;
  // mode bits travel in the same control write that sets write-start,
  // so the start decode must see them before they land in the register
  wire ctl_now = hit_ctl && idle;
  wire regs_nxt = ctl_now ? wdata_r[CTL_REGS_BIT] : regs_r;
  wire latch_only_nxt = ctl_now ? wdata_r[CTL_LATCH_ONLY_BIT] : latch_only_r;
  wire free_nxt = ctl_now ? wdata_r[CTL_FREE_BIT] : free_r;
  wire write_enable_bit_nxt = ctl_now ? wdata_r[CTL_WRITE_ENABLE_BIT_BIT] : write_enable_bit_r;
  wire [15:0] full_addr = {regs_nxt, addr_r};
  // start only after a clean 55/AA pair
  wire start_req = hit_ctl && wdata_r[CTL_WR_BIT] && idle;
  wire start_ok = start_req && unl_b_r && write_enable_bit_nxt;
  // the unlock is spent by any other register write in between
  wire unl_break = (unl_a_r || unl_b_r) && wr_fire && !hit_unl
                   && !start_req;
  wire start_bad = start_req && !unl_b_r;
  wire reg_wr_ok = (full_addr >= UID_LO && full_addr <= UID_HI) ||
                   (full_addr >= CFG_LO && full_addr <= CFG_HI);
  wire reg_rd_ok = reg_wr_ok ||
                   (full_addr >= DEVID_LO && full_addr <= DEVID_HI) ||
                   (full_addr >= INFO_LO && full_addr <= INFO_HI);
  // region side is protected outside writable words
  wire protect = regs_nxt ? !reg_wr_ok : prot_hit;
  wire do_load = start_ok && !free_nxt && latch_only_nxt;
  wire do_erase = start_ok && free_nxt && !protect;
  wire do_prog = start_ok && !free_nxt && !latch_only_nxt && !protect;
  wire prot_fail = start_ok && !(!free_nxt && latch_only_nxt) && protect;
  wire rd_start = hit_ctl && wdata_r[0] && idle;
  wire op_end = state_r == ST_DONE;
  wire cnt_end = cnt_r == 16'(PROG_CNT - 1);
  wire [31:0] ctl_view = {22'h0, ie_r, done_r, 1'b0, regs_r, latch_only_r,
                          free_r, err_r, write_enable_bit_r, wr_r, 1'b0};
  wire [31:0] rd_mux =
    (s_axi_araddr == ADDR_PAIR_OFS) ? {16'h0, 1'b0, addr_r} :
    (s_axi_araddr == DATA_PAIR_OFS) ? {18'h0, data_r} :
    (s_axi_araddr == CONTROL_OFS) ? ctl_view : 32'h0000_0000;
  wire rd_known = s_axi_araddr == ADDR_PAIR_OFS ||
                  s_axi_araddr == DATA_PAIR_OFS ||
                  s_axi_araddr == CONTROL_OFS ||
                  s_axi_araddr == UNLOCK_OFS;

  // ***********************************************************
  // write channel capture
  // ***********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // read channel: answers register reads without waiting on a pending flash read
  // ***********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // control, unlock and error
  // ***********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {regs_r, latch_only_r, free_r, write_enable_bit_r, wr_r, done_r, ie_r} <= 7'h00;
      err_r <= 1'b0;
      unl_a_r <= 1'b0;
      unl_b_r <= 1'b0;
      addr_r <= 15'h0000;
      data_r <= 14'h0000;
      rd_pend_r <= 1'b0;
    end else begin
      if (hit_addr && idle) addr_r <= wdata_r[14:0];
      if (hit_data && idle) data_r <= wdata_r[13:0];
      if (hit_ctl && idle) begin
        regs_r <= wdata_r[CTL_REGS_BIT];
        latch_only_r <= wdata_r[CTL_LATCH_ONLY_BIT];
        free_r <= wdata_r[CTL_FREE_BIT];
        write_enable_bit_r <= wdata_r[CTL_WRITE_ENABLE_BIT_BIT];
        ie_r <= wdata_r[CTL_IE_BIT];
        done_r <= wdata_r[CTL_DONE_BIT];
      end
      if (hit_unl) begin
        unl_a_r <= wdata_r[7:0] == UNLOCK_CODE_A;
        unl_b_r <= unl_a_r && wdata_r[7:0] == UNLOCK_CODE_B;
      end else if (wr_fire) begin
        unl_a_r <= 1'b0;
        unl_b_r <= 1'b0;
      end
      // clear from software, set events win over it
      if (hit_ctl) err_r <= wdata_r[CTL_ERR_BIT];
      if (prot_fail || start_bad || unl_break || reset_mid_write)
        err_r <= 1'b1;
      if (do_erase || do_prog) wr_r <= 1'b1;
      if (op_end) wr_r <= 1'b0;
      if (op_end && flash_erase_r) done_r <= 1'b1;
      if (rd_start) rd_pend_r <= 1'b1;
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        data_r <= (regs_r && !reg_rd_ok) ? 14'h0000 : flash_rdata;
      end
    end
  end

  // ***********************************************************
  // write latches
  // ***********************************************************
  generate
    for (genvar i = 0; i < ROW_WORDS; i++) begin : g_latch
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          latch_r[i] <= BLANK_WORD;
        end else if (op_end) begin
          latch_r[i] <= BLANK_WORD;
        end else if (do_load && addr_r[4:0] == 5'(i)) begin
          latch_r[i] <= data_r;
        end
      end
    end
  endgenerate

  // ***********************************************************
  // self-timed sequencer; walks the row one word per step
  // ***********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 16'h0000;
      word_r <= 5'h00;
      flash_prog_r <= 1'b0;
      flash_erase_r <= 1'b0;
      flash_req_r.addr <= 16'h0000;
      flash_req_r.wdata <= 14'h0000;
      flash_req_r.rd_req <= 1'b0;
      flash_req_r.word <= 5'h00;
      cpu_stall_r <= 1'b0;
      done_irq_r <= 1'b0;
    end else begin
      flash_req_r.rd_req <= rd_start;
      done_irq_r <= done_r && ie_r;
      case (state_r)
        ST_IDLE: begin
          cnt_r <= 16'h0000;
          word_r <= 5'h00;
          flash_req_r.word <= 5'h00;
          flash_req_r.addr <= {full_addr[15:5], 5'h00};
          if (rd_start) flash_req_r.addr <= full_addr;
          // no erase is slipped in ahead of a program
          if (do_prog) begin
            state_r <= ST_PROG;
            flash_prog_r <= 1'b1;
            cpu_stall_r <= 1'b1;
          end else if (do_erase) begin
            state_r <= ST_ERASE;
            flash_erase_r <= 1'b1;
            cpu_stall_r <= 1'b1;
          end
        end
        ST_PROG: begin
          // one row only: word index wraps inside the row
          flash_req_r.addr <= {full_addr[15:5], word_r};
          flash_req_r.wdata <= latch_r[word_r];
          flash_req_r.word <= word_r;
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_end) begin
            cnt_r <= 16'h0000;
            word_r <= word_r + 5'h01;
            if (word_r == 5'(ROW_WORDS - 1)) state_r <= ST_DONE;
          end
        end
        ST_ERASE: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_end) state_r <= ST_DONE;
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
          flash_prog_r <= 1'b0;
          flash_erase_r <= 1'b0;
          cpu_stall_r <= 1'b0;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  property p_blank_after;
    @(posedge aclk) disable iff (!aresetn)
      op_end |=> latch_r[0] == BLANK_WORD && latch_r[31] == BLANK_WORD;
  endproperty
  a_blank_after: assert property (p_blank_after)
    else $error("latches not blank after operation");

  property p_no_start_locked;
    @(posedge aclk) disable iff (!aresetn)
      start_req && !unl_b_r |=> !wr_r && err_r;
  endproperty
  a_no_start_locked: assert property (p_no_start_locked)
    else $error("start without unlock took effect");

  property p_prot_err;
    @(posedge aclk) disable iff (!aresetn)
      prot_fail |=> err_r && !wr_r && idle;
  endproperty
  a_prot_err: assert property (p_prot_err)
    else $error("protected start not refused");

  property p_write_enable_bit_block;
    @(posedge aclk) disable iff (!aresetn)
      idle && !write_enable_bit_nxt |=> idle;
  endproperty
  a_write_enable_bit_block: assert property (p_write_enable_bit_block)
    else $error("operation started with write disabled");

  property p_stall;
    @(posedge aclk) disable iff (!aresetn)
      !idle && !op_end |-> cpu_stall_r && wr_r;
  endproperty
  a_stall: assert property (p_stall)
    else $error("cpu not stalled during operation");

  property p_err_sticky;
    @(posedge aclk) disable iff (!aresetn)
      err_r && !hit_ctl |=> err_r;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error flag cleared by hardware");

  property p_load;
    @(posedge aclk) disable iff (!aresetn)
      do_load && !op_end |=> latch_r[$past(addr_r[4:0])] == $past(data_r);
  endproperty
  a_load: assert property (p_load)
    else $error("latch load lost");

  property p_erase_done;
    @(posedge aclk) disable iff (!aresetn)
      state_r == ST_ERASE && cnt_end |=> op_end ##1 done_r;
  endproperty
  a_erase_done: assert property (p_erase_done)
    else $error("erase completion flag missing");
endmodule : fwl_sequencer

// >>> fwl_sequencer_tb_top.sv
`timescale 1ns/1ps
module fwl_sequencer_tb_top;
  import fwl_pkg::*;
  // ***********************************************************
  // stimulus and observation
  // ***********************************************************
  localparam int PCNT = 2;
  localparam logic [31:0] K_RD = 32'h0000_0001;
  localparam logic [31:0] K_WR = 32'h0000_0002;
  localparam logic [31:0] K_WRITE_ENABLE_BIT = 32'h0000_0004;
  localparam logic [31:0] K_ERR = 32'h0000_0008;
  localparam logic [31:0] K_FREE = 32'h0000_0010;
  localparam logic [31:0] K_LATCH_ONLY = 32'h0000_0020;
  localparam logic [31:0] K_REGS = 32'h0000_0040;
  localparam logic [31:0] K_DONE = 32'h0000_0100;
  localparam logic [31:0] K_IE = 32'h0000_0200;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] aw_a = 8'h00;
  logic [7:0] ar_a = 8'h00;
  logic [31:0] w_d = 32'h0000_0000;
  logic aw_v = 1'b0;
  logic w_v = 1'b0;
  logic b_r = 1'b0;
  logic ar_v = 1'b0;
  logic r_r = 1'b0;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_d;
  logic [13:0] f_rd = 14'h0000;
  logic prot = 1'b0;
  logic rst_mid = 1'b0;
  fwl_flash_req_type req;
  logic prog, erase, stall, irq;
  logic [13:0] cap [32];
  logic [31:0] mask;
  logic [9:0] row_seen;
  int prog_cyc = 0;
  int erase_cyc = 0;
  int n_fail = 0;
  int cmp_count = 0;
  int p0, e0, i;
  logic [31:0] d;
  logic [15:0] ra [12] = '{16'h8000, 16'h8004, 16'h8003, 16'h800C,
    16'h8005, 16'h80FF, 16'h8006, 16'h8300, 16'h8007, 16'h8100,
    16'h800B, 16'h82FF};
  logic ok [12] = '{1, 0, 1, 0, 1, 0, 1, 0, 1, 1, 1, 1};

  always #10 aclk = ~aclk;

  fwl_sequencer #(.PROG_CNT(PCNT)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
    .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_v), .s_axi_rready(r_r), .flash_rdata(f_rd),
    .prot_hit(prot), .reset_mid_write(rst_mid), .flash_req_r(req),
    .flash_prog_r(prog), .flash_erase_r(erase), .cpu_stall_r(stall),
    .done_irq_r(irq));

  // the array is worked only while a row program walks or an erase runs
  always @(posedge aclk) begin
    if (prog === 1'b1) begin
      cap[req.word] = req.wdata;
      mask[req.word] = 1'b1;
      row_seen = req.addr[14:5];
      prog_cyc++;
      chk({31'h0, stall}, 32'h0000_0001, "stall");
    end
    if (erase === 1'b1) erase_cyc++;
  end

  // ***********************************************************
  // bus tasks
  // ***********************************************************
  task automatic give_verdict;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, exp, input string what);
    begin
      cmp_count++;
      if (got !== exp) begin
        n_fail++;
        $display("wrong value at %0t: %s got %h exp %h", $time, what,
          got, exp);
      end
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    begin
      n = 0;
      @(posedge aclk);
      aw_a <= a;
      w_d <= v;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      do begin
        @(posedge aclk);
        n++;
        if (aw_rdy === 1'b1) aw_v <= 1'b0;
        if (w_rdy === 1'b1) w_v <= 1'b0;
      end while (b_v !== 1'b1 && n < 100);
      b_r <= 1'b0;
      chk({30'h0, b_resp}, {30'h0, RESP_OKAY}, "bresp");
      if (n >= 100) begin
        n_fail++;
        give_verdict();
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] rs);
    int n;
    begin
      n = 0;
      @(posedge aclk);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      do begin
        @(posedge aclk);
        n++;
        if (ar_rdy === 1'b1) ar_v <= 1'b0;
      end while (r_v !== 1'b1 && n < 100);
      r_r <= 1'b0;
      v = r_d;
      rs = r_resp;
      if (n >= 100) begin
        n_fail++;
        give_verdict();
      end
    end
  endtask : axi_rd

  task automatic ctl(input logic [31:0] m, exp, input string what);
    logic [1:0] rs;
    begin
      axi_rd(CONTROL_OFS, d, rs);
      chk(d & m, exp, what);
    end
  endtask : ctl

  // polling keeps the bench free of any assumed operation length
  task automatic wait_clr(input logic [31:0] m);
    logic [1:0] rs;
    int n;
    begin
      n = 0;
      do begin
        axi_rd(CONTROL_OFS, d, rs);
        n++;
      end while ((d & m) !== 32'h0 && n < 100);
      if (n >= 100) begin
        n_fail++;
        give_verdict();
      end
    end
  endtask : wait_clr

  task automatic start_op(input logic [31:0] mode);
    begin
      p0 = prog_cyc;
      e0 = erase_cyc;
      mask = 32'h0000_0000;
      axi_wr(UNLOCK_OFS, {24'h0, UNLOCK_CODE_A});
      axi_wr(UNLOCK_OFS, {24'h0, UNLOCK_CODE_B});
      axi_wr(CONTROL_OFS, mode | K_WR);
      wait_clr(K_WR);
    end
  endtask : start_op

  // ***********************************************************
  // sequence
  // ***********************************************************
  initial begin
    logic [1:0] rs;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    ctl(32'hFFFF_FFFF, 32'h0, "control reset");
    axi_rd(8'h10, d, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped resp");
    chk(d, 32'h0, "unmapped data");
    // latch loads while the row is protected
    prot <= 1'b1;
    axi_wr(CONTROL_OFS, K_WRITE_ENABLE_BIT | K_LATCH_ONLY);
    axi_wr(ADDR_PAIR_OFS, 32'h0000_0040);
    axi_wr(DATA_PAIR_OFS, 32'h0000_1ABC);
    start_op(K_WRITE_ENABLE_BIT | K_LATCH_ONLY);
    axi_wr(ADDR_PAIR_OFS, 32'h0000_0045);
    axi_wr(DATA_PAIR_OFS, 32'h0000_0123);
    start_op(K_WRITE_ENABLE_BIT | K_LATCH_ONLY);
    chk(prog_cyc - p0, 0, "load touched array");
    ctl(K_ERR, 32'h0, "load error");
    prot <= 1'b0;
    start_op(K_WRITE_ENABLE_BIT);
    chk(mask, 32'hFFFF_FFFF, "words programmed");
    chk({18'h0, cap[0]}, 32'h0000_1ABC, "word 0");
    chk({18'h0, cap[5]}, 32'h0000_0123, "word 5");
    chk({18'h0, cap[1]}, {18'h0, BLANK_WORD}, "unloaded");
    chk({22'h0, row_seen}, 32'h0000_0002, "row");
    chk(erase_cyc - e0, 0, "auto erase");
    ctl(K_WR | K_ERR, 32'h0, "start bit after program");
    start_op(K_WRITE_ENABLE_BIT);
    chk({18'h0, cap[0]}, {18'h0, BLANK_WORD}, "latch reset");
    chk({18'h0, cap[5]}, {18'h0, BLANK_WORD}, "latch reset");
    start_op(K_WRITE_ENABLE_BIT | K_FREE | K_LATCH_ONLY | K_IE);
    chk(prog_cyc - p0, 0, "erase programmed");
    chk(32'(erase_cyc > e0), 32'h1, "erase ran");
    ctl(K_DONE, K_DONE, "done flag");
    chk({31'h0, irq}, 32'h1, "done irq");
    axi_wr(CONTROL_OFS, 32'h0);
    prot <= 1'b1;
    start_op(K_WRITE_ENABLE_BIT);
    chk(prog_cyc - p0, 0, "protected program");
    ctl(K_ERR | K_WR, K_ERR, "protected error");
    axi_wr(CONTROL_OFS, 32'h0);
    ctl(K_ERR, 32'h0, "error clear");
    start_op(K_WRITE_ENABLE_BIT | K_FREE);
    chk(erase_cyc - e0, 0, "protected erase");
    ctl(K_ERR, K_ERR, "protected erase error");
    prot <= 1'b0;
    axi_wr(CONTROL_OFS, 32'h0);
    // unlock broken by another write between the codes
    axi_wr(UNLOCK_OFS, {24'h0, UNLOCK_CODE_A});
    axi_wr(ADDR_PAIR_OFS, 32'h0000_0040);
    axi_wr(UNLOCK_OFS, {24'h0, UNLOCK_CODE_B});
    p0 = prog_cyc;
    axi_wr(CONTROL_OFS, K_WRITE_ENABLE_BIT | K_WR);
    wait_clr(K_WR);
    chk(prog_cyc - p0, 0, "broken unlock");
    ctl(K_ERR, K_ERR, "broken unlock error");
    axi_wr(CONTROL_OFS, 32'h0);
    start_op(32'h0);
    chk(prog_cyc - p0, 0, "write disabled");
    axi_wr(CONTROL_OFS, K_ERR);
    ctl(K_ERR, K_ERR, "software set");
    axi_wr(CONTROL_OFS, 32'h0);
    @(posedge aclk);
    rst_mid <= 1'b1;
    @(posedge aclk);
    rst_mid <= 1'b0;
    ctl(K_ERR, K_ERR, "reset mid write");
    axi_wr(CONTROL_OFS, 32'h0);
    // region reads alternate valid and invalid for the first eight, then four valid, to expose clearing
    f_rd <= 14'h1234;
    for (i = 0; i < 12; i++) begin
      axi_wr(ADDR_PAIR_OFS, {17'h0, ra[i][14:0]});
      axi_wr(CONTROL_OFS, K_REGS | K_RD);
      wait_clr(K_RD);
      axi_rd(DATA_PAIR_OFS, d, rs);
      chk(d & 32'h0000_3FFF, ok[i] ? 32'h1234 : 32'h0, "region");
    end
    axi_wr(ADDR_PAIR_OFS, {17'h0, DEVID_LO[14:0]});
    start_op(K_REGS | K_WRITE_ENABLE_BIT);
    chk(prog_cyc - p0, 0, "id word written");
    ctl(K_ERR, K_ERR, "id word error");
    axi_wr(CONTROL_OFS, 32'h0);
    axi_wr(ADDR_PAIR_OFS, {17'h0, UID_LO[14:0]});
    start_op(K_REGS | K_WRITE_ENABLE_BIT);
    chk(32'(prog_cyc > p0), 32'h1, "user id write");
    ctl(K_ERR, 32'h0, "user id error");
    give_verdict();
  end
endmodule : fwl_sequencer_tb_top
